// ==== rtl/sed_decoder.sv ====
// Opcode decoder, status register and write-protection logic of an SPI EEPROM slave.
// Assumes SPI mode 0 or 3 master; array and id-page storage live elsewhere.
`timescale 1ns/100ps
module sed_decoder (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic protect_pin_n_in,
    output logic so_out,
    output logic so_oe_n_out,
    output logic busy_out,
    output logic array_wr_req_out,
    output logic [8:0] array_addr_out,
    output logic array_rd_sel_out,
    output logic id_page_sel_out,
    output logic id_lock_sel_out,
    output logic [7:0] status_out
);
    import sed_pkg::*;

    typedef enum logic [1:0] {SED_OPC, SED_ADDR, SED_DATA, SED_IGNORE} sed_phase_e;

    // Link domain: everything below up to the crossing runs on sck_in
    sed_phase_e phase_q;
    sed_phase_e phase_now;
    sed_phase_e phase_d;
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_now;
    logic [7:0] shift_q;
    logic [7:0] opc_q;
    logic [7:0] addr_q;
    logic [7:0] data_q;
    logic data_full_q;
    logic data_full_now;
    logic srd_q;
    logic fresh_q;
    logic byte_done;
    logic [7:0] so_shift_q;
    logic so_act_q;
    logic [7:0] snap_q;
    logic [7:0] shift_d;
    logic [7:0] opc_m;
    logic opc_known;
    logic opc_has_addr;
    logic opc_is_srd;

    assign shift_d = {shift_q[6:0], si_in};
    assign opc_m = shift_d & OPC_MASK;

    always_comb begin
        opc_known = 1'b1;
        opc_has_addr = 1'b0;
        opc_is_srd = 1'b0;
        unique case (opc_m)
            OPC_SET_WEL, OPC_CLR_WEL, OPC_STAT_WR: opc_known = 1'b1;
            OPC_STAT_RD: opc_is_srd = 1'b1;
            OPC_ARR_RD, OPC_ARR_WR: opc_has_addr = 1'b1;
            8'h83, 8'h82: opc_has_addr = ~shift_d[OPC_A8_BIT];
            default: opc_known = 1'b0;
        endcase
        if (opc_m == OPC_ID_RD || opc_m == OPC_ID_WR) begin
            opc_known = ~shift_d[OPC_A8_BIT];
        end
    end

    // Frame start flag: set while deselected, cleared by the first sck rise of a frame
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // Masked on the first edge, not reset by chip select, so the system side
    // still reads the finished frame; a frame with no clock edge is not supported
    assign bit_cnt_now = fresh_q ? 3'h0 : bit_cnt_q;
    assign phase_now = fresh_q ? SED_OPC : phase_q;
    assign data_full_now = fresh_q ? 1'b0 : data_full_q;
    assign byte_done = (bit_cnt_now == 3'h7);

    always_comb begin
        phase_d = phase_now;
        if (byte_done) begin
            unique case (phase_now)
                SED_OPC: begin
                    if (!opc_known) begin
                        phase_d = SED_IGNORE;
                    end else if (opc_has_addr) begin
                        phase_d = SED_ADDR;
                    end else begin
                        phase_d = SED_DATA;
                    end
                end
                SED_ADDR: phase_d = SED_DATA;
                SED_DATA: phase_d = SED_DATA;
                SED_IGNORE: phase_d = SED_IGNORE;
            endcase
        end
    end

    always_ff @(posedge sck_in) begin
        bit_cnt_q <= bit_cnt_now + 3'h1;
        shift_q <= shift_d;
        phase_q <= phase_d;
    end

    always_ff @(posedge sck_in) begin
        if (byte_done && phase_now == SED_OPC) begin
            opc_q <= shift_d;
            srd_q <= opc_is_srd;
        end
    end

    always_ff @(posedge sck_in) begin
        if (byte_done && phase_now == SED_ADDR) begin
            addr_q <= shift_d;
        end
    end

    always_ff @(posedge sck_in) begin
        if (byte_done && phase_now == SED_DATA) begin
            data_q <= shift_d;
        end
    end

    always_ff @(posedge sck_in) begin
        data_full_q <= data_full_now | (byte_done && phase_now == SED_DATA);
    end

    // Status snapshot crosses as a quasi-static word, stable between writes
    logic [7:0] status_q;
    logic busy_q;
    always_ff @(posedge sck_in) begin
        if (byte_done && phase_now == SED_OPC) begin
            snap_q <= status_out;
        end
    end

    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            so_shift_q <= 8'h00;
            so_act_q <= 1'b0;
        end else if (!fresh_q && phase_q == SED_DATA && srd_q) begin
            so_act_q <= 1'b1;
            if (bit_cnt_q == 3'h0) begin
                so_shift_q <= snap_q;
            end else begin
                so_shift_q <= {so_shift_q[6:0], 1'b0};
            end
        end
    end
    assign so_out = so_shift_q[7];
    assign so_oe_n_out = ~so_act_q;

    // System domain: frame end detected through a two-flop chip select synchroniser
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic pin_s1_q, pin_s2_q;
    always_ff @(posedge sys_clk_in) begin
        cs_s1_q <= cs_n_in;
        cs_s2_q <= cs_s1_q;
        cs_s3_q <= cs_s2_q;
    end

    always_ff @(posedge sys_clk_in) begin
        pin_s1_q <= protect_pin_n_in;
        pin_s2_q <= pin_s1_q;
    end
    logic frame_end;
    assign frame_end = cs_s2_q & ~cs_s3_q;
    // Frame registers are held constant while chip select stays high, so read safely
    logic [7:0] opc_c;
    assign opc_c = opc_q & OPC_MASK;
    logic byte_whole;
    assign byte_whole = (bit_cnt_q == 3'h0);

    logic frame_ok;
    assign frame_ok = frame_end && !busy_q && phase_q != SED_IGNORE && byte_whole;
    logic id_opc;
    assign id_opc = (opc_c == OPC_ID_RD || opc_c == OPC_ID_WR);

    sed_cmd_e cmd;
    always_comb begin
        cmd = SED_CMD_NONE;
        if (frame_ok) begin
            if (phase_q == SED_DATA && opc_c == OPC_SET_WEL) begin
                cmd = SED_CMD_SET_WEL;
            end else if (phase_q == SED_DATA && opc_c == OPC_CLR_WEL) begin
                cmd = SED_CMD_CLR_WEL;
            end else if (data_full_q && opc_c == OPC_STAT_WR) begin
                cmd = SED_CMD_STAT_WR;
            end else if (data_full_q && opc_c == OPC_ARR_WR) begin
                cmd = SED_CMD_ARR_WR;
            end else if (data_full_q && opc_c == OPC_ID_WR) begin
                cmd = SED_CMD_ID_WR;
            end
        end
    end

    logic hw_protect;
    assign hw_protect = status_q[ST_ARM] & ~pin_s2_q;
    logic status_wr_ok;
    assign status_wr_ok = status_q[ST_WEL] & ~hw_protect;

    logic [8:0] full_addr;
    assign full_addr = {opc_q[OPC_A8_BIT], addr_q};
    logic guarded;
    always_comb begin
        unique case ({status_q[ST_BG_HI], status_q[ST_BG_LO]})
            2'h0: guarded = 1'b0;
            2'h1: guarded = full_addr >= GUARD_BASE_Q;
            2'h2: guarded = full_addr >= GUARD_BASE_H;
            2'h3: guarded = full_addr >= GUARD_BASE_ALL;
        endcase
    end
    logic array_ok;
    assign array_ok = status_q[ST_WEL] & ~guarded;

    // Write cycle timer
    localparam int CNT_W = $clog2(WRITE_CYCLE_CYC + 1);
    logic [CNT_W-1:0] wr_cnt_q;
    logic start_wr;
    logic wr_done;
    assign start_wr = (cmd == SED_CMD_STAT_WR && status_wr_ok) ||
                      (cmd == SED_CMD_ARR_WR && array_ok) ||
                      (cmd == SED_CMD_ID_WR && status_q[ST_WEL]);
    assign wr_done = busy_q && wr_cnt_q == '0;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_cnt_q <= '0;
        end else if (start_wr) begin
            wr_cnt_q <= CNT_W'(WRITE_CYCLE_CYC - 1);
        end else if (busy_q && wr_cnt_q != '0) begin
            wr_cnt_q <= wr_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
        end else if (start_wr) begin
            busy_q <= 1'b1;
        end else if (wr_done) begin
            busy_q <= 1'b0;
        end
    end

    // Status contents; guard bits model non-volatile cells with delivered state on reset
    logic arm_q, wel_q;
    logic [1:0] guard_q;
    logic [7:0] wr_val_q;
    logic stat_pend_q;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wel_q <= 1'b0;
        end else if (cmd == SED_CMD_SET_WEL) begin
            wel_q <= 1'b1;
        end else if (cmd == SED_CMD_CLR_WEL || cmd == SED_CMD_STAT_WR || cmd == SED_CMD_ARR_WR) begin
            wel_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stat_pend_q <= 1'b0;
        end else if (cmd == SED_CMD_STAT_WR && status_wr_ok) begin
            stat_pend_q <= 1'b1;
        end else if (wr_done) begin
            stat_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_val_q <= 8'h00;
        end else if (cmd == SED_CMD_STAT_WR && status_wr_ok) begin
            wr_val_q <= data_q;
        end
    end

    // New guard and arm values only land when the write cycle completes
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            guard_q <= GUARD_RESET;
        end else if (stat_pend_q && wr_done) begin
            guard_q <= {wr_val_q[ST_BG_HI], wr_val_q[ST_BG_LO]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            arm_q <= 1'b0;
        end else if (stat_pend_q && wr_done && (wr_val_q[ST_ARM] || pin_s2_q)) begin
            arm_q <= wr_val_q[ST_ARM];
        end
    end

    always_comb begin
        status_q = 8'h00;
        status_q[ST_ARM] = arm_q;
        status_q[ST_BG_HI] = guard_q[1];
        status_q[ST_BG_LO] = guard_q[0];
        status_q[ST_WEL] = wel_q;
    end
    assign status_out = busy_q ? STATUS_BUSY_VAL : status_q;
    assign busy_out = busy_q;

    // Array handshake outputs registered in the system domain
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            array_wr_req_out <= 1'b0;
        end else begin
            array_wr_req_out <= cmd == SED_CMD_ARR_WR && array_ok;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            array_addr_out <= 9'h000;
        end else if (frame_end) begin
            array_addr_out <= full_addr;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            array_rd_sel_out <= 1'b0;
        end else if (frame_end) begin
            array_rd_sel_out <= opc_c == OPC_ARR_RD && !busy_q;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            id_page_sel_out <= 1'b0;
        end else if (frame_end) begin
            id_page_sel_out <= id_opc && !addr_q[ADDR_LOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            id_lock_sel_out <= 1'b0;
        end else if (frame_end) begin
            id_lock_sel_out <= id_opc && addr_q[ADDR_LOCK_BIT];
        end
    end
endmodule

// ==== rtl/sed_pkg.sv ====
// Constants for the serial EEPROM status and opcode decoder.
// Assumes a single system clock; the link side runs on the serial clock pin.
package sed_pkg;
    localparam int SYS_CLK_HZ = 50000000;
    // Self-timed write cycle, in microseconds
    localparam int WRITE_CYCLE_US = 4000;
    localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_US * (SYS_CLK_HZ / 1000000));
    // Opcode field layout and codes with bit 3 forced to zero; bit 3 is A8 for array codes and must be zero for id codes
    localparam logic [7:0] OPC_MASK = 8'hf7;
    localparam logic [7:0] OPC_SET_WEL = 8'h06;
    localparam logic [7:0] OPC_CLR_WEL = 8'h04;
    localparam logic [7:0] OPC_STAT_RD = 8'h05;
    localparam logic [7:0] OPC_STAT_WR = 8'h01;
    localparam logic [7:0] OPC_ARR_RD = 8'h03;
    localparam logic [7:0] OPC_ARR_WR = 8'h02;
    localparam logic [7:0] OPC_ID_RD = 8'h83;
    localparam logic [7:0] OPC_ID_WR = 8'h82;
    localparam int OPC_A8_BIT = 3;
    localparam int ADDR_LOCK_BIT = 7;
    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BG_LO = 2;
    localparam int ST_BG_HI = 3;
    localparam int ST_ARM = 7;
    localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;
    localparam logic [1:0] GUARD_RESET = 2'h0;
    // Protected region bases per guard setting
    localparam logic [8:0] GUARD_BASE_Q = 9'h180;
    localparam logic [8:0] GUARD_BASE_H = 9'h100;
    localparam logic [8:0] GUARD_BASE_ALL = 9'h000;
    // Command codes handed from the link domain
    typedef enum logic [2:0] {
        SED_CMD_NONE,
        SED_CMD_SET_WEL,
        SED_CMD_CLR_WEL,
        SED_CMD_STAT_WR,
        SED_CMD_ARR_WR,
        SED_CMD_ID_WR
    } sed_cmd_e;
endpackage

// ==== sim/sed_decoder_properties.sv ====
// Concurrent checks on the status and opcode decoder ports.
// Assumes the system clock domain; serial pins are sampled as plain levels.
`timescale 1ns/100ps
module sed_decoder_properties (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic protect_pin_n_in,
    input wire logic so_out,
    input wire logic so_oe_n_out,
    input wire logic busy_out,
    input wire logic array_wr_req_out,
    input wire logic [8:0] array_addr_out,
    input wire logic array_rd_sel_out,
    input wire logic id_page_sel_out,
    input wire logic id_lock_sel_out,
    input wire logic [7:0] status_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    function automatic logic in_guard(input logic [8:0] a, input logic [1:0] g);
        case (g)
            2'h1: in_guard = (a >= 9'h180);
            2'h2: in_guard = (a >= 9'h100);
            2'h3: in_guard = 1'b1;
            default: in_guard = 1'b0;
        endcase
    endfunction
    AST_BUSY_ALL_ONES: assert property (busy_out |-> status_out == 8'hff)
        else $error("status not all ones while busy");
    AST_IDLE_BITS: assert property (!busy_out |-> status_out[0] == 1'b0 && status_out[6:4] == 3'h0)
        else $error("idle status shows busy or spare bits");
    // Frame lasts several clocks, so four back lands inside it
    AST_WR_NEEDS_WEL: assert property (array_wr_req_out |-> $past(status_out[1], 4))
        else $error("array write without latch");
    AST_WR_OUTSIDE_GUARD: assert property (
        array_wr_req_out |-> !in_guard(array_addr_out, $past(status_out[3:2], 4)))
        else $error("array write inside guarded region");
    AST_WR_STARTS_BUSY: assert property (array_wr_req_out |-> ##[0:3] busy_out)
        else $error("array write did not start write cycle");
    AST_WEL_AFTER_FRAME: assert property (
        $rose(status_out[1]) && !busy_out && !$past(busy_out) |-> $past(cs_n_in))
        else $error("latch set before frame end");
    AST_SO_RELEASED: assert property (cs_n_in && $past(cs_n_in) |-> so_oe_n_out)
        else $error("serial out driven while deselected");
    AST_GUARD_ARM_STABLE: assert property (
        !busy_out && !$past(busy_out) && !$past(rst_in) |-> $stable(status_out[7:2]))
        else $error("guard or arm changed outside write cycle");
    AST_SEL_EXCLUSIVE: assert property (id_page_sel_out |-> !id_lock_sel_out)
        else $error("page and lock both selected");
endmodule
bind sed_decoder sed_decoder_properties u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sck_in(sck_in),
    .cs_n_in(cs_n_in), .si_in(si_in), .protect_pin_n_in(protect_pin_n_in), .so_out(so_out),
    .so_oe_n_out(so_oe_n_out), .busy_out(busy_out), .array_wr_req_out(array_wr_req_out),
    .array_addr_out(array_addr_out), .array_rd_sel_out(array_rd_sel_out), .id_page_sel_out(id_page_sel_out),
    .id_lock_sel_out(id_lock_sel_out), .status_out(status_out));

// ==== sim/sed_spi_master.sv ====
// Behavioural serial bus master, mode 0, 6 ns clock period.
// Assumes the caller leaves at least four system clocks between frames.
`timescale 1ns/100ps
module sed_spi_master (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in
);
    initial begin
        sck_out = 1'b0;
        si_out = 1'b0;
        // Late rise so the slave surely sees a deselect edge at start-up
        #0.5 cs_n_out = 1'b1;
    end
    // Clock stands still outside frames; last byte of serial out kept
    task automatic xfer(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] dat,
                        input int nb, output logic [7:0] rx);
        logic [23:0] sh;
        sh = {op, adr, dat};
        rx = 8'h00;
        #1.7 cs_n_out = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            si_out = sh[23 - i];
            #3 sck_out = 1'b1;
            if (i >= 8) rx = {rx[6:0], so_in};
            #3 sck_out = 1'b0;
        end
        #1 cs_n_out = 1'b1;
        si_out = ~si_out;
    endtask
endmodule

// ==== sim/spi_eeprom_status_and_opcode_decode_test.sv ====
// Self-checking bench for the status and opcode decoder.
// Assumes the serial master model; write cycles are too long to finish here.
`timescale 1ns/100ps
module spi_eeprom_status_and_opcode_decode_test;
    import sed_pkg::*;
    logic sys_clk, rst, pin_n, sck, cs_n, si, so, so_oe_n, busy, wr_req, rd_sel, id_pg, id_lk;
    logic [8:0] addr;
    logic [7:0] status, rx;
    int error_cnt, checks, wr_cnt;
    sed_decoder i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .protect_pin_n_in(pin_n), .so_out(so), .so_oe_n_out(so_oe_n), .busy_out(busy),
        .array_wr_req_out(wr_req), .array_addr_out(addr), .array_rd_sel_out(rd_sel),
        .id_page_sel_out(id_pg), .id_lock_sel_out(id_lk), .status_out(status));
    sed_spi_master u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (wr_req === 1'b1) wr_cnt++;
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Six clocks covers the hand-over plus the gap between frames
    task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d, input int nb);
        u_host.xfer(op, a, d, nb, rx);
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_latch;
        logic [7:0] ops [4] = '{8'h06, 8'h0e, 8'h04, 8'h0c};
        for (int i = 0; i < 4; i++) begin
            cmd(ops[i], 8'h00, 8'h00, 1);
            check(9'(status[1]), 9'(i < 2));
        end
    endtask
    task automatic t_status_rd;
        cmd(8'h06, 8'h00, 8'h00, 1);
        cmd(8'h05, 8'h00, 8'h00, 2);
        check(9'(rx), 9'h002);
        check(9'(so_oe_n), 9'h001);
    endtask
    task automatic t_undef;
        pin_n = 1'b0;
        cmd(8'h40, 8'hff, 8'hff, 3);
        check(9'(status), 9'h002);
        check(9'(wr_cnt), 9'h000);
        pin_n = 1'b1;
    endtask
    task automatic t_reads;
        cmd(8'h0b, 8'h5a, 8'h00, 2);
        check({rd_sel, addr[7:0]}, 9'h15a);
        check(addr, 9'h15a);
        cmd(8'h03, 8'h5a, 8'h00, 2);
        check(addr, 9'h05a);
        cmd(8'h83, 8'h05, 8'h00, 2);
        check(9'({id_pg, id_lk}), 9'h002);
        cmd(8'h83, 8'h80, 8'h00, 2);
        check(9'({id_pg, id_lk}), 9'h001);
    endtask
    task automatic t_refused;
        cmd(8'h04, 8'h00, 8'h00, 1);
        cmd(8'h02, 8'h10, 8'h55, 3);
        check(9'(wr_cnt), 9'h000);
        cmd(8'h01, 8'h8c, 8'h00, 2);
        check({busy, status}, 9'h000);
    endtask
    // Last on purpose: the write cycle outlasts the run, so no 4 ms wait; polled instead
    task automatic t_write;
        cmd(8'h06, 8'h00, 8'h00, 1);
        cmd(8'h0a, 8'h33, 8'haa, 3);
        check(9'(wr_cnt), 9'h001);
        check(addr, 9'h133);
        check({busy, status}, 9'h1ff);
        cmd(8'h05, 8'h00, 8'h00, 2);
        check(9'(rx), 9'h0ff);
        cmd(8'h05, 8'h00, 8'h00, 2);
        check(9'(rx), 9'h0ff);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        pin_n = 1'b1;
        error_cnt = 0;
        checks = 0;
        wr_cnt = 0;
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({busy, status}, 9'h000);
        check(9'(so_oe_n), 9'h001);
        t_latch;
        t_status_rd;
        t_undef;
        t_reads;
        t_refused;
        t_write;
        tally_and_finish;
    end
endmodule
